// *** pkg/tmr_pkg.sv ***
/*
 Constants for the dual 16-bit timer prescaler, edge select and port
 direction block. Assumes byte-wide memory-mapped register access.
*/
package tmr_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_PORT0_DIRECTION = 16'hFF20;
   localparam logic [15:0] ADDR_TIMER1_CES = 16'hFFB7;
   localparam logic [15:0] ADDR_TIMER0_CES = 16'hFFBB;
   // ----------------------------------------------------------------
   // Reset values and fixed bits
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PORT0_DIRECTION = 8'hFF;
   localparam logic [7:0] RST_CES = 8'h00;
   localparam logic [7:0] CES_WRITE_MASK = 8'hF3;
   localparam logic [7:0] DIR_FIXED_ONES = 8'h80;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CLK_SEL_LSB = 0;
   localparam int FIRST_EDGE_LSB = 4;
   localparam int SECOND_EDGE_LSB = 6;
   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] CLK_PERIPH = 2'h0;
   localparam logic [1:0] CLK_DIV_A = 2'h1;
   localparam logic [1:0] CLK_DIV_B = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
   // ----------------------------------------------------------------
   // Prescale ratios, as powers of two
   // ----------------------------------------------------------------
   localparam int T0_DIV_A_LOG2 = 2;
   localparam int T0_DIV_B_LOG2 = 8;
   localparam int T1_DIV_A_LOG2 = 4;
   localparam int T1_DIV_B_LOG2 = 6;
   localparam int PRESCALE_W = 8;
   localparam int COUNT_W = 16;
endpackage

// *** logic/timer_channel.sv ***
/*
 One timer channel: input edge detection, count clock selection and
 the clear-on-match interval counter. Assumes synchronous pins and a
 free-running prescaler supplied by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_channel
   import tmr_pkg::*;
#(
   parameter int DIV_A_LOG2 = 2,
   parameter int DIV_B_LOG2 = 8
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_ces,
   input wire logic [1:0] i_op_mode,
   input wire logic [COUNT_W-1:0] i_compare_reg_a,
   input wire logic [PRESCALE_W-1:0] i_prescale,
   input wire logic i_first_input_pin,
   input wire logic i_second_input_pin,
   output logic [COUNT_W-1:0] o_timer_count,
   output logic o_match_irq_a,
   output logic o_first_edge,
   output logic o_second_edge
);
   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   logic [1:0] first_smp_reg;
   logic [1:0] second_smp_reg;
   logic first_lvl_reg;
   logic second_lvl_reg;
   logic armed_reg;
   logic ever_run_reg;
   logic running;
   logic first_edge;
   logic second_edge;
   logic count_tick;

   assign running = (i_op_mode != MODE_STOP);

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic prev,
                                     input logic now);
      logic rise;
      logic fall;
      rise = !prev && now;
      fall = prev && !now;
      unique case (sel)
         EDGE_FALL: edge_hit = fall;
         EDGE_RISE: edge_hit = rise;
         EDGE_BOTH: edge_hit = rise || fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   // Two equal samples in a row accept a new level
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         first_smp_reg <= 2'h0;
         second_smp_reg <= 2'h0;
      end else begin
         first_smp_reg <= {first_smp_reg[0], i_first_input_pin};
         second_smp_reg <= {second_smp_reg[0], i_second_input_pin};
      end
   end

   // First enable sees a low reference, so a high pin reads as a rise
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         first_lvl_reg <= 1'b0;
         second_lvl_reg <= 1'b0;
         armed_reg <= 1'b0;
         ever_run_reg <= 1'b0;
      end else begin
         armed_reg <= running;
         if (running) begin
            ever_run_reg <= 1'b1;
         end
         if (first_smp_reg[1] == first_smp_reg[0]) begin
            first_lvl_reg <= first_smp_reg[1];
         end
         if (second_smp_reg[1] == second_smp_reg[0]) begin
            second_lvl_reg <= second_smp_reg[1];
         end
         if (running && !armed_reg && !ever_run_reg) begin
            first_lvl_reg <= 1'b0;
            second_lvl_reg <= 1'b0;
         end
      end
   end

   assign first_edge = running && armed_reg &&
      (first_smp_reg[1] == first_smp_reg[0]) &&
      edge_hit(i_ces[FIRST_EDGE_LSB+:2], first_lvl_reg, first_smp_reg[1]);
   assign second_edge = running && armed_reg &&
      (second_smp_reg[1] == second_smp_reg[0]) &&
      edge_hit(i_ces[SECOND_EDGE_LSB+:2], second_lvl_reg,
               second_smp_reg[1]);

   // ----------------------------------------------------------------
   // Count clock selection
   // ----------------------------------------------------------------
   always_comb begin
      unique case (i_ces[CLK_SEL_LSB+:2])
         CLK_PERIPH: count_tick = 1'b1;
         CLK_DIV_A: count_tick = (i_prescale[DIV_A_LOG2-1:0] == '0);
         CLK_DIV_B: count_tick = (i_prescale[DIV_B_LOG2-1:0] == '0);
         CLK_EXT: count_tick = first_edge;
      endcase
   end

   // ----------------------------------------------------------------
   // Interval counter
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_timer_count <= '0;
         o_match_irq_a <= 1'b0;
      end else begin
         o_match_irq_a <= 1'b0;
         if (!running) begin
            o_timer_count <= '0;
         end else if (i_op_mode == MODE_CLR_MATCH && count_tick) begin
            // Period is compare + 1 ticks
            if (o_timer_count == i_compare_reg_a) begin
               o_timer_count <= '0;
               o_match_irq_a <= 1'b1;
            end else begin
               o_timer_count <= o_timer_count + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_first_edge <= 1'b0;
         o_second_edge <= 1'b0;
      end else begin
         o_first_edge <= first_edge;
         o_second_edge <= second_edge;
      end
   end
endmodule // timer_channel
`default_nettype wire

// *** logic/timer_prescaler_edge_interval.sv ***
/*
 Top of the dual timer prescaler and edge select block with the port
 direction register. Assumes a byte bus with single-cycle write strobe,
 a bit-write strobe for single-bit manipulation, and that the mode,
 compare and output control registers live outside.
 Software keeps a select register still while its timer runs.
*/
// Summary of operation
// - Each select register picks count clock and both input pin edges.
// - Reset clears both select registers.
// - Select registers accept byte writes and single-bit writes.
// - High pin at first enable counts as rising; not after restart.
// - Edge code 00 falling, 01 rising, 11 both; fields at 7:6, 5:4.
// - Timer 0 clock: peripheral, divide by 4, by 256, or pin edge.
// - Timer 1 clock: peripheral, divide by 16, by 64, or pin edge.
// - Direction bit 0 drives output, 1 is input; bit 7 reads one.
// - Reset sets direction register to all ones.
// - Mode 11 counts in step with the selected clock.
// - Counter equal to compare clears to zero and raises match.
// - Mode 00 clears the counter and stops it.
// - Interval is compare plus one ticks; compare zero not allowed.
// - Pins sampled each clock; edge needs two equal samples.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_edge_interval
   import tmr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_addr,
   input wire logic i_wr_byte,
   input wire logic i_wr_bit,
   input wire logic [2:0] i_bit_pos,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd,
   input wire logic [1:0] i_t0_op_mode,
   input wire logic [1:0] i_t1_op_mode,
   input wire logic [COUNT_W-1:0] i_t0_compare_reg_a,
   input wire logic [COUNT_W-1:0] i_t1_compare_reg_a,
   input wire logic i_t0_first_input_pin,
   input wire logic i_timer0_second_in,
   input wire logic i_t1_first_input_pin,
   input wire logic i_timer1_second_in,
   output logic [7:0] o_rdata,
   output logic [7:0] o_port_dir_reg,
   output logic [COUNT_W-1:0] o_t0_timer_count,
   output logic [COUNT_W-1:0] o_t1_timer_count,
   output logic o_t0_match_irq_a,
   output logic o_t1_match_irq_a,
   output logic o_t0_first_edge,
   output logic o_t0_second_edge,
   output logic o_t1_first_edge,
   output logic o_t1_second_edge
);
   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] t0_ces_reg;
   logic [7:0] t1_ces_reg;
   logic [7:0] dir_reg;
   logic [PRESCALE_W-1:0] prescale_reg;

   // ----------------------------------------------------------------
   // Write merge
   // ----------------------------------------------------------------
   // Byte write replaces; bit write changes only the addressed bit
   function automatic logic [7:0] wr_merge(input logic [7:0] cur,
                                           input logic byte_wr,
                                           input logic [2:0] pos,
                                           input logic [7:0] wd);
      logic [7:0] v;
      v = cur;
      if (byte_wr) begin
         v = wd;
      end else begin
         v[pos] = wd[0];
      end
      wr_merge = v;
   endfunction

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // One-hot select, shared by the write and the read path
   function automatic logic [2:0] reg_hit(input logic [15:0] addr);
      logic [2:0] h;
      h = 3'h0;
      h[0] = (addr == ADDR_TIMER0_CES);
      h[1] = (addr == ADDR_TIMER1_CES);
      h[2] = (addr == ADDR_PORT0_DIRECTION);
      reg_hit = h;
   endfunction

   // Either strobe writes; the byte strobe wins over the bit strobe
   logic wr_any;
   logic [2:0] hit;
   logic [7:0] rd_mux;
   assign wr_any = i_wr_byte || i_wr_bit;
   assign hit = reg_hit(i_addr);

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Writes while running are software's fault and are not blocked
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         t0_ces_reg <= RST_CES;
      end else if (wr_any && hit[0]) begin
         t0_ces_reg <= wr_merge(t0_ces_reg, i_wr_byte, i_bit_pos,
                                i_wdata) & CES_WRITE_MASK;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         t1_ces_reg <= RST_CES;
      end else if (wr_any && hit[1]) begin
         t1_ces_reg <= wr_merge(t1_ces_reg, i_wr_byte, i_bit_pos,
                                i_wdata) & CES_WRITE_MASK;
      end
   end

   // Bit 7 has no pin mode to choose and stays an input
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dir_reg <= RST_PORT0_DIRECTION;
      end else if (wr_any && hit[2]) begin
         dir_reg <= wr_merge(dir_reg, i_wr_byte, i_bit_pos, i_wdata)
                    | DIR_FIXED_ONES;
      end
   end

   assign o_port_dir_reg = dir_reg; // 0 = output buffer on

   // ----------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------
   // Unmapped addresses read as zero
   always_comb begin
      rd_mux = 8'h00;
      if (hit[0]) begin
         rd_mux = t0_ces_reg;
      end
      if (hit[1]) begin
         rd_mux = t1_ces_reg;
      end
      if (hit[2]) begin
         rd_mux = dir_reg;
      end
   end

   // Read data stand until the next read strobe
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Shared prescaler
   // ----------------------------------------------------------------
   // Eight bits cover the slowest divider, the divide by 256
   // Free-running, so a divided clock's first tick lands anywhere
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prescale_reg <= '0;
      end else begin
         prescale_reg <= prescale_reg + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   // Both channels share the prescaler, so their divided ticks align
   // Timer 0 divides by 4 or by 256
   timer_channel #(
      .DIV_A_LOG2(T0_DIV_A_LOG2),
      .DIV_B_LOG2(T0_DIV_B_LOG2)
   ) u_timer0 (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_ces(t0_ces_reg),
      .i_op_mode(i_t0_op_mode),
      .i_compare_reg_a(i_t0_compare_reg_a),
      .i_prescale(prescale_reg),
      .i_first_input_pin(i_t0_first_input_pin),
      .i_second_input_pin(i_timer0_second_in),
      .o_timer_count(o_t0_timer_count),
      .o_match_irq_a(o_t0_match_irq_a),
      .o_first_edge(o_t0_first_edge),
      .o_second_edge(o_t0_second_edge)
   );

   // Timer 1 divides by 16 or by 64
   timer_channel #(
      .DIV_A_LOG2(T1_DIV_A_LOG2),
      .DIV_B_LOG2(T1_DIV_B_LOG2)
   ) u_timer1 (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_ces(t1_ces_reg),
      .i_op_mode(i_t1_op_mode),
      .i_compare_reg_a(i_t1_compare_reg_a),
      .i_prescale(prescale_reg),
      .i_first_input_pin(i_t1_first_input_pin),
      .i_second_input_pin(i_timer1_second_in),
      .o_timer_count(o_t1_timer_count),
      .o_match_irq_a(o_t1_match_irq_a),
      .o_first_edge(o_t1_first_edge),
      .o_second_edge(o_t1_second_edge)
   );
endmodule // timer_prescaler_edge_interval
`default_nettype wire

// *** tb/tpei_asserts.sv ***
/*
 Port checker for the timer prescaler, edge select and direction block.
 Assumes binding to the top module, one clock and async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tpei_asserts
   import tmr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_addr,
   input wire logic i_wr_byte,
   input wire logic i_wr_bit,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [1:0] i_t0_op_mode,
   input wire logic [COUNT_W-1:0] i_t0_compare_reg_a,
   input wire logic [COUNT_W-1:0] i_t1_compare_reg_a,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_port_dir_reg,
   input wire logic [COUNT_W-1:0] o_t0_timer_count,
   input wire logic [COUNT_W-1:0] o_t1_timer_count,
   input wire logic o_t0_match_irq_a,
   input wire logic o_t1_match_irq_a,
   input wire logic o_t1_first_edge
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   AST_DIR_MSB: assert property (o_port_dir_reg[7])
      else $error("direction bit 7 low");
   AST_DIR_WR: assert property (i_wr_byte && i_addr == 16'hFF20 |=>
      o_port_dir_reg == ($past(i_wdata) | 8'h80))
      else $error("direction byte write lost");
   AST_DIR_HOLD: assert property (
      !((i_wr_byte || i_wr_bit) && i_addr == 16'hFF20)
      |=> $stable(o_port_dir_reg)) else $error("direction changed alone");
   AST_RD_DIR: assert property (i_rd && !i_wr_byte && !i_wr_bit &&
      i_addr == 16'hFF20 |=> o_rdata == $past(o_port_dir_reg))
      else $error("direction read wrong");
   AST_RD_CES: assert property (i_rd && (i_addr == 16'hFFBB ||
      i_addr == 16'hFFB7) |=> o_rdata[3:2] == 2'h0)
      else $error("select bits 3:2 not zero");
   AST_STOP: assert property (i_t0_op_mode == 2'h0 |=>
      o_t0_timer_count == 16'h0000) else $error("stopped count not zero");
   AST_T0_MATCH: assert property (o_t0_match_irq_a |->
      o_t0_timer_count == 16'h0000 &&
      $past(o_t0_timer_count) == $past(i_t0_compare_reg_a))
      else $error("timer 0 match without equal count");
   AST_T1_MATCH: assert property (o_t1_match_irq_a |->
      o_t1_timer_count == 16'h0000 &&
      $past(o_t1_timer_count) == $past(i_t1_compare_reg_a))
      else $error("timer 1 match without equal count");
   AST_T0_STEP: assert property (
      o_t0_timer_count != $past(o_t0_timer_count) |->
      o_t0_timer_count == $past(o_t0_timer_count) + 16'h1 ||
      o_t0_timer_count == 16'h0000) else $error("count jumped");
   AST_MATCH_PULSE: assert property (o_t0_match_irq_a |=>
      !o_t0_match_irq_a) else $error("match pulse too long");
   COV_T0_MATCH: cover property (o_t0_match_irq_a);
   COV_T1_EDGE: cover property (o_t1_first_edge);
   COV_DIR_BIT: cover property (i_wr_bit && i_addr == 16'hFF20);
endmodule // tpei_asserts
`default_nettype wire

// *** tb/pin_stim_model.sv ***
/*
 Far-side model of the four timer input pins.
 Assumes the bench changes i_level by non-blocking assignment.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_stim_model (
   input wire logic i_clock,
   input wire logic i_fast,
   input wire logic [3:0] i_level,
   output logic [3:0] o_pin
);
   logic [1:0] hold_reg;
   initial begin
      o_pin = 4'h0;
      hold_reg = 2'h0;
   end
   // Level held long enough for the filter; fast only for glitch tests
   always @(negedge i_clock) begin
      if (i_level != o_pin && (i_fast || hold_reg == 2'h0)) begin
         o_pin <= i_level;
         hold_reg <= 2'h3;
      end else if (hold_reg != 2'h0) begin
         hold_reg <= hold_reg - 2'h1;
      end
   end
endmodule // pin_stim_model
`default_nettype wire

// *** tb/timer_prescaler_edge_interval_bench.sv ***
/*
 Self-checking bench for the timer prescaler block.
 Assumes the pin model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_edge_interval_bench;
   import tmr_pkg::*;
   logic i_clock, i_sys_rst, i_wr_byte, i_wr_bit, i_rd, fast;
   logic [15:0] i_addr, cmp0, cmp1;
   logic [2:0] i_bit_pos, p;
   logic [7:0] i_wdata, o_rdata, o_port_dir_reg, rd, d, ex8;
   logic [1:0] i_t0_op_mode, i_t1_op_mode;
   logic [3:0] lvl, pin, ep;
   logic [15:0] o_t0_timer_count, o_t1_timer_count;
   logic o_t0_match_irq_a, o_t1_match_irq_a;
   int n_errors = 0, cmp_count = 0, ecnt[4] = '{0, 0, 0, 0};
   int n, m, e0, e1, ex;
   logic [15:0] ra[4] = '{16'hFF20, 16'hFFB7, 16'hFFBB, 16'hFF00};
   logic [7:0] rv[4] = '{8'hFF, 8'h00, 8'h00, 8'h00};
   logic [1:0] codes[4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, 2'h2};
   timer_prescaler_edge_interval uut (
      .i_clock, .i_sys_rst, .i_addr, .i_wr_byte, .i_wr_bit, .i_bit_pos,
      .i_wdata, .i_rd, .i_t0_op_mode, .i_t1_op_mode,
      .i_t0_compare_reg_a(cmp0), .i_t1_compare_reg_a(cmp1),
      .i_t0_first_input_pin(pin[0]), .i_timer0_second_in(pin[1]),
      .i_t1_first_input_pin(pin[2]), .i_timer1_second_in(pin[3]),
      .o_rdata, .o_port_dir_reg, .o_t0_timer_count, .o_t1_timer_count,
      .o_t0_match_irq_a, .o_t1_match_irq_a, .o_t0_first_edge(ep[0]),
      .o_t0_second_edge(ep[1]), .o_t1_first_edge(ep[2]),
      .o_t1_second_edge(ep[3]));
   pin_stim_model pins (.i_clock, .i_fast(fast), .i_level(lvl), .o_pin(pin));
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   always @(posedge i_clock) for (int k = 0; k < 4; k++)
      if (ep[k] === 1'b1) ecnt[k]++;
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(logic [15:0] got, logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(logic [15:0] a, logic [7:0] wd, logic wb, logic wt,
                      logic r, logic [2:0] bp);
      @(negedge i_clock);
      i_addr = a;
      i_wdata = wd;
      i_wr_byte = wb;
      i_wr_bit = wt;
      i_rd = r;
      i_bit_pos = bp;
      @(negedge i_clock);
      i_wr_byte = 1'b0;
      i_wr_bit = 1'b0;
      i_rd = 1'b0;
      rd = o_rdata;
   endtask
   task automatic run(int t, logic [1:0] v);
      @(negedge i_clock);
      if (t == 1) i_t1_op_mode = v;
      else i_t0_op_mode = v;
   endtask
   task automatic pulse(int i, int w);
      @(negedge i_clock);
      lvl[i] <= 1'b1;
      repeat (w) @(negedge i_clock);
      lvl[i] <= 1'b0;
      repeat (w) @(negedge i_clock);
   endtask
   // Bounded wait for the next match pulse; n is cycles waited
   task automatic wmatch(int t, output int nc);
      nc = 0;
      do begin
         @(negedge i_clock);
         nc++;
      end while ((t ? o_t1_match_irq_a : o_t0_match_irq_a) !== 1'b1 &&
                 nc < 3000);
      if (nc >= 3000) begin
         n_errors++;
         $display("wrong value at %0t: no match pulse", $time);
         results();
      end
   endtask
   function automatic logic [15:0] cesa(int t);
      return t ? ADDR_TIMER1_CES : ADDR_TIMER0_CES;
   endfunction
   function automatic int period(int t, int s, int mv);
      int dv;
      dv = (s == 1) ? (t ? 16 : 4) : (s == 2) ? (t ? 64 : 256) : 1;
      return (mv + 1) * dv;
   endfunction
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      i_sys_rst = 1'b1;
      {i_wr_byte, i_wr_bit, i_rd, fast, i_addr, i_wdata, i_bit_pos} = '0;
      {i_t0_op_mode, i_t1_op_mode, lvl} = '0;
      cmp0 = 16'hF000;
      cmp1 = 16'hF000;
      void'($urandom(54628));
      repeat (6) @(negedge i_clock);
      i_sys_rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(ra[i], 8'h00, 1'b0, 1'b0, 1'b1, 3'h0);
         check(16'(rd), 16'(rv[i]));
      end
      for (int i = 1; i < 3; i++) begin
         bus(ra[i], 8'hFF, 1'b1, 1'b0, 1'b0, 3'h0);
         bus(ra[i], 8'h00, 1'b0, 1'b0, 1'b1, 3'h0);
         check(16'(rd), 16'h00F3);
         bus(ra[i], 8'h01, 1'b0, 1'b1, 1'b0, 3'h2);
         bus(ra[i], 8'h00, 1'b0, 1'b1, 1'b0, 3'h7);
         bus(ra[i], 8'h00, 1'b0, 1'b0, 1'b1, 3'h0);
         check(16'(rd), 16'h0073);
         bus(ra[i], 8'h00, 1'b1, 1'b0, 1'b0, 3'h0);
      end
      ex8 = 8'hFF;
      repeat (8) begin
         d = 8'($urandom);
         p = 3'($urandom);
         if (d[0]) begin
            bus(16'hFF20, d, 1'b1, 1'b0, 1'b0, 3'h0);
            ex8 = d | 8'h80;
         end else begin
            bus(16'hFF20, {7'h0, d[1]}, 1'b0, 1'b1, 1'b0, p);
            ex8[p] = (p == 3'h7) ? 1'b1 : d[1];
         end
         bus(16'hFF21, 8'h00, 1'b1, 1'b0, 1'b0, 3'h0);
         bus(16'hFF20, 8'h00, 1'b0, 1'b0, 1'b1, 3'h0);
         check(16'(rd), 16'(ex8));
         check(16'(o_port_dir_reg), 16'(ex8));
      end
      $display("test registers done");
      bus(cesa(1), 8'h10, 1'b1, 1'b0, 1'b0, 3'h0);
      lvl[2] <= 1'b1;
      repeat (6) @(negedge i_clock);
      e0 = ecnt[2];
      run(1, MODE_CLR_MATCH);
      repeat (8) @(negedge i_clock);
      check(16'(ecnt[2] - e0), 16'h1);
      run(1, MODE_STOP);
      repeat (4) @(negedge i_clock);
      e0 = ecnt[2];
      run(1, MODE_CLR_MATCH);
      repeat (8) @(negedge i_clock);
      check(16'(ecnt[2] - e0), 16'h0);
      run(1, MODE_STOP);
      lvl[2] <= 1'b0;
      repeat (6) @(negedge i_clock);
      $display("test first enable done");
      for (int t = 0; t < 2; t++) for (int s = 0; s < 3; s++) begin
         m = (s == 0) ? 1 : 1 + $urandom % 4;
         bus(cesa(t), 8'(s), 1'b1, 1'b0, 1'b0, 3'h0);
         if (t == 1) cmp1 = 16'(m);
         else cmp0 = 16'(m);
         run(t, MODE_CLR_MATCH);
         wmatch(t, n);
         wmatch(t, n);
         check(16'(n), 16'(period(t, s, m)));
         run(t, MODE_STOP);
         repeat (2) @(negedge i_clock);
         check(t ? o_t1_timer_count : o_t0_timer_count, 16'h0);
      end
      $display("test interval done");
      cmp0 = 16'hF000;
      cmp1 = 16'hF000;
      for (int t = 0; t < 2; t++) foreach (codes[i]) begin
         e0 = ecnt[2 * t];
         e1 = ecnt[2 * t + 1];
         bus(cesa(t), {codes[i], codes[i], 4'h0}, 1'b1, 1'b0, 1'b0, 3'h0);
         run(t, MODE_CLR_MATCH);
         pulse(2 * t, 5);
         pulse(2 * t + 1, 5);
         repeat (8) @(negedge i_clock);
         ex = (codes[i] == 2'h3) ? 2 : (codes[i] == 2'h2) ? 0 : 1;
         check(16'(ecnt[2 * t] - e0), 16'(ex));
         check(16'(ecnt[2 * t + 1] - e1), 16'(ex));
         run(t, MODE_STOP);
      end
      $display("test edge codes done");
      // External clock only; the pin is not a capture or restart source
      for (int t = 0; t < 2; t++) begin
         bus(cesa(t), 8'h13, 1'b1, 1'b0, 1'b0, 3'h0);
         run(t, MODE_CLR_MATCH);
         repeat (4) @(negedge i_clock);
         n = int'(t ? o_t1_timer_count : o_t0_timer_count);
         repeat (3) pulse(2 * t, 4);
         repeat (8) @(negedge i_clock);
         m = int'(t ? o_t1_timer_count : o_t0_timer_count);
         check(16'(m), 16'(n + 3));
         run(t, MODE_STOP);
      end
      bus(cesa(0), 8'h30, 1'b1, 1'b0, 1'b0, 3'h0);
      run(0, MODE_CLR_MATCH);
      fast = 1'b1;
      e0 = ecnt[0];
      pulse(0, 1);
      repeat (8) @(negedge i_clock);
      check(16'(ecnt[0] - e0), 16'h0);
      fast = 1'b0;
      run(0, MODE_STOP);
      $display("test external clock done");
      results();
   end
endmodule // timer_prescaler_edge_interval_bench
bind timer_prescaler_edge_interval tpei_asserts chk (
   .i_clock, .i_sys_rst, .i_addr, .i_wr_byte, .i_wr_bit, .i_rd, .i_wdata,
   .i_t0_op_mode, .i_t0_compare_reg_a, .i_t1_compare_reg_a, .o_rdata,
   .o_port_dir_reg, .o_t0_timer_count, .o_t1_timer_count,
   .o_t0_match_irq_a, .o_t1_match_irq_a, .o_t1_first_edge);
`default_nettype wire
